// ### rlmp_bank.sv
// Lock monitor, two PPM groups and figure of merit register bank of one retimer channel.
// Assumes the host port is on clk; lock and signal detect arrive asynchronously.
module rlmp_bank
  import rlmp_pkg::*;
#(
  parameter int          INTERVAL_CYCLES = EYE_INTERVAL_CYCLES,
  parameter logic [14:0] G0_FIXED_COUNT  = 15'h0000,
  parameter logic [3:0]  G0_FIXED_TOL    = 4'h0,
  parameter logic [14:0] G1_FIXED_COUNT  = 15'h0000,
  parameter logic [3:0]  G1_FIXED_TOL    = 4'h0
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Channel status
  input  wire logic       cdr_lock_raw,
  input  wire logic       sig_detect_raw,
  input  wire logic       adapt_done,
  input  wire logic       mon_enable,
  input  wire logic [1:0] interval_sel,
  input  rlmp_eye_t       eye,
  // Channel control
  output logic            adapt_lowdiv_en,
  output rlmp_ppm_t       ppm_g0,
  output rlmp_ppm_t       ppm_g1,
  output logic            eye_monitoring,
  output logic            eye_meas_req,
  output logic            eye_below_thr,
  output logic      [7:0] readback_h,
  output logic      [7:0] readback_v,
  output logic      [9:0] merit_score
);

  initial begin
    if (INTERVAL_CYCLES < 1 || INTERVAL_CYCLES * 4 >= (1 << TIMER_W)) begin
      $error("rlmp_bank interval does not fit the timer");
    end
  end

  logic [1:0]         rst_sync;
  logic               rst_n;
  rlmp_state_t        s;
  rlmp_state_t        next_s;
  logic [EV_W-1:0]    ev_set;
  logic [EV_W-1:0]    ev_flags;
  logic               ev_clr;
  logic               lock_s;
  logic               sig_s;
  logic               lock_rise;
  logic               lock_fall;
  logic               sig_rise;
  logic               sig_fall;
  logic [TIMER_W-1:0] interval_len;
  logic [3:0]         every_n;
  logic [9:0]         score_now;
  logic [7:0]         merit_h;
  logic [7:0]         merit_v;

  // Reset is released synchronously so that no flop leaves reset on a split edge.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign lock_s    = s.lock_sync[1];
  assign sig_s     = s.sig_sync[1];
  assign lock_rise = lock_s & ~s.lock_prev;
  assign lock_fall = ~lock_s & s.lock_prev;
  assign sig_rise  = sig_s & ~s.sig_prev;
  assign sig_fall  = ~sig_s & s.sig_prev;

  always_comb begin
    ev_set                   = '0;
    ev_set[EV_LOCK_BIT]      = lock_rise;
    ev_set[EV_LOCK_LOSS_BIT] = lock_fall;
    ev_set[EV_SIG_ACQ_BIT]   = sig_rise;
    ev_set[EV_SIG_LOSS_BIT]  = sig_fall;
  end

  assign ev_clr = reg_rd && (reg_addr == OFS_EVENTS);

  rlmp_sticky #(
    .W (EV_W)
  ) u_events (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (ev_set),
    .clr   (ev_clr),
    .flags (ev_flags)
  );

  // The merit is scored from whichever openings the readback currently shows.
  assign merit_h = s.regs.adapt_opt[ADAPT_ALT_BIT] ? eye.alt_heo : eye.horizontal_eye_opening;
  assign merit_v = s.regs.adapt_opt[ADAPT_ALT_BIT] ? eye.alt_veo : eye.vertical_eye_opening;

  rlmp_merit u_merit (
    .horizontal_eye_opening    (merit_h),
    .vertical_eye_opening    (merit_v),
    .term_a (s.regs.merit_a),
    .term_b (s.regs.merit_b),
    .term_c (s.regs.merit_c),
    .score  (score_now)
  );

  // Only monitor once lock is declared and adaptation is done.
  assign eye_monitoring = mon_enable & lock_s & adapt_done;

  // The outside timing field stretches the base interval by one to four times.
  assign interval_len = TIMER_W'(INTERVAL_CYCLES) * TIMER_W'({interval_sel} + 3'h1);
  assign every_n      = (s.regs.eye_intv == 4'h0) ? 4'h1 : s.regs.eye_intv;

  always_comb begin
    next_s           = s;
    next_s.lock_sync = {s.lock_sync[0], cdr_lock_raw};
    next_s.sig_sync  = {s.sig_sync[0], sig_detect_raw};
    next_s.lock_prev = lock_s;
    next_s.sig_prev  = sig_s;
    next_s.meas_req  = 1'b0;

    // Interval timer and measurement divider.
    if (!eye_monitoring) begin
      next_s.timer    = '0;
      next_s.intv_cnt = 4'h0;
    end else if (s.timer >= interval_len - TIMER_W'(1)) begin
      next_s.timer = '0;
      if (s.intv_cnt + 4'h1 >= every_n) begin
        next_s.intv_cnt = 4'h0;
        next_s.meas_req = 1'b1;
      end else begin
        next_s.intv_cnt = s.intv_cnt + 4'h1;
      end
    end else begin
      next_s.timer = s.timer + TIMER_W'(1);
    end

    // Eye result capture.
    if (eye.valid) begin
      if (s.regs.adapt_opt[ADAPT_ALT_BIT]) begin
        next_s.readback_h = eye.alt_heo;
        next_s.readback_v = eye.alt_veo;
      end else begin
        next_s.readback_h = eye.horizontal_eye_opening;
        next_s.readback_v = eye.vertical_eye_opening;
      end
      next_s.score = score_now;
      if (eye_monitoring) begin
        next_s.eye_low = (eye.vertical_eye_opening[7:4] < s.regs.eye_thr[7:4])
                       | (eye.horizontal_eye_opening[7:4] < s.regs.eye_thr[3:0]);
      end
    end

    // Register writes; reserved bits and spare registers keep their reset values.
    if (reg_wr) begin
      case (reg_addr)
        OFS_ADAPT_OPT: next_s.regs.adapt_opt = reg_wdata & ADAPT_OPT_WMASK;
        OFS_G0_LO:     next_s.regs.g0_lo     = reg_wdata;
        OFS_G0_HI:     next_s.regs.g0_hi     = reg_wdata;
        OFS_G1_LO:     next_s.regs.g1_lo     = reg_wdata;
        OFS_G1_HI:     next_s.regs.g1_hi     = reg_wdata;
        OFS_TOL:       next_s.regs.tol       = reg_wdata;
        OFS_EYE_INTV:  next_s.regs.eye_intv  = reg_wdata[3:0];
        OFS_EYE_THR:   next_s.regs.eye_thr   = reg_wdata;
        OFS_MERIT_A:   next_s.regs.merit_a   = reg_wdata;
        OFS_MERIT_B:   next_s.regs.merit_b   = reg_wdata;
        OFS_MERIT_C:   next_s.regs.merit_c   = reg_wdata;
        default: begin
        end
      endcase
    end

    if (reg_rd) begin
      case (reg_addr)
        OFS_ADAPT_OPT: next_s.rdata = s.regs.adapt_opt;
        OFS_EVENTS:    next_s.rdata = {{(8-EV_W){1'b0}}, ev_flags};
        OFS_G0_LO:     next_s.rdata = s.regs.g0_lo;
        OFS_G0_HI:     next_s.rdata = s.regs.g0_hi;
        OFS_G1_LO:     next_s.rdata = s.regs.g1_lo;
        OFS_G1_HI:     next_s.rdata = s.regs.g1_hi;
        OFS_TOL:       next_s.rdata = s.regs.tol;
        OFS_EYE_INTV:  next_s.rdata = {4'h0, s.regs.eye_intv};
        OFS_EYE_THR:   next_s.rdata = s.regs.eye_thr;
        OFS_MERIT_A:   next_s.rdata = s.regs.merit_a;
        OFS_MERIT_B:   next_s.rdata = s.regs.merit_b;
        OFS_MERIT_C:   next_s.rdata = s.regs.merit_c;
        default:       next_s.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s                <= '0;
      s.regs.adapt_opt <= RST_ADAPT_OPT;
      s.regs.g0_lo     <= RST_COUNT;
      s.regs.g0_hi     <= RST_COUNT;
      s.regs.g1_lo     <= RST_COUNT;
      s.regs.g1_hi     <= RST_COUNT;
      s.regs.tol       <= RST_TOL;
      s.regs.eye_intv  <= RST_EYE_INTV;
      s.regs.eye_thr   <= RST_EYE_THR;
      s.regs.merit_a   <= RST_MERIT_A;
      s.regs.merit_b   <= RST_MERIT_B;
      s.regs.merit_c   <= RST_MERIT_C;
    end else begin
      s <= next_s;
    end
  end

  // Override replaces the built-in group constants with register values.
  always_comb begin
    if (s.regs.g0_hi[OVR_BIT]) begin
      ppm_g0.count = {s.regs.g0_hi[6:0], s.regs.g0_lo};
      ppm_g0.tol   = s.regs.tol[7:4];
    end else begin
      ppm_g0.count = G0_FIXED_COUNT;
      ppm_g0.tol   = G0_FIXED_TOL;
    end
    if (s.regs.g1_hi[OVR_BIT]) begin
      ppm_g1.count = {s.regs.g1_hi[6:0], s.regs.g1_lo};
      ppm_g1.tol   = s.regs.tol[3:0];
    end else begin
      ppm_g1.count = G1_FIXED_COUNT;
      ppm_g1.tol   = G1_FIXED_TOL;
    end
  end

  assign adapt_lowdiv_en = s.regs.adapt_opt[ADAPT_LOWDIV_BIT];
  assign reg_rdata       = s.rdata;
  assign eye_meas_req    = s.meas_req;
  assign eye_below_thr   = s.eye_low;
  assign readback_h      = s.readback_h;
  assign readback_v      = s.readback_v;
  assign merit_score     = s.score;

  sequence lock_edge_s;
    lock_rise;
  endsequence

  sequence events_read_s;
    reg_rd && reg_addr == OFS_EVENTS;
  endsequence

  lock_event_a: assert property (@(posedge clk) disable iff (!rst_n)
    lock_edge_s |=> ev_flags[EV_LOCK_BIT])
    else $error("lock event flag not set");

  lock_loss_a: assert property (@(posedge clk) disable iff (!rst_n)
    lock_fall ##1 !(reg_rd && reg_addr == OFS_EVENTS) |=> ev_flags[EV_LOCK_LOSS_BIT])
    else $error("loss of lock flag lost");

  signal_event_a: assert property (@(posedge clk) disable iff (!rst_n)
    sig_rise || sig_fall |=> ev_flags[EV_SIG_ACQ_BIT] || ev_flags[EV_SIG_LOSS_BIT])
    else $error("signal event flag not set");

  read_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    events_read_s |=> reg_rdata == $past(ev_flags, 1) && ev_flags == $past(ev_set, 1))
    else $error("event read did not return and clear flags");

  clear_race_a: assert property (@(posedge clk) disable iff (!rst_n)
    events_read_s and lock_edge_s |=> ev_flags[EV_LOCK_BIT])
    else $error("event lost during clearing read");

  group0_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFS_G0_HI && reg_wdata[OVR_BIT]
    |=> ppm_g0.count[14:8] == $past(reg_wdata[6:0], 1))
    else $error("group zero override count wrong");

  group1_tol_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFS_TOL && s.regs.g1_hi[OVR_BIT]
    |=> ppm_g1.tol == $past(reg_wdata[3:0], 1))
    else $error("group one override tolerance wrong");

  lowdiv_en_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFS_ADAPT_OPT |=> adapt_lowdiv_en == $past(reg_wdata[0], 1))
    else $error("lower divide adaptation enable wrong");

  alt_readback_a: assert property (@(posedge clk) disable iff (!rst_n)
    eye.valid && s.regs.adapt_opt[ADAPT_ALT_BIT] |=> readback_h == $past(eye.alt_heo, 1))
    else $error("alternate readback not shown");

  meas_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    eye_meas_req |-> $past(eye_monitoring, 1))
    else $error("measurement requested while not monitoring");

  vert_thr_a: assert property (@(posedge clk) disable iff (!rst_n)
    eye.valid && eye_monitoring && eye.vertical_eye_opening[7:4] < s.regs.eye_thr[7:4] |=> eye_below_thr)
    else $error("vertical threshold miss not flagged");

  spare_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr >= OFS_SPARE_A && reg_addr <= OFS_SPARE_D |=> reg_rdata == 8'h00)
    else $error("spare register not reading zero");

endmodule

// ### rlmp_pkg.sv
// Constants, register layout and carrier types for the lock monitor and PPM bank.
// Assumes a single register clock of 50 MHz shared by the host port and the bank.
package rlmp_pkg;

  // Register offsets.
  localparam logic [7:0] OFS_ADAPT_OPT = 8'h55;
  localparam logic [7:0] OFS_EVENTS    = 8'h56;
  localparam logic [7:0] OFS_G0_LO     = 8'h60;
  localparam logic [7:0] OFS_G0_HI     = 8'h61;
  localparam logic [7:0] OFS_G1_LO     = 8'h62;
  localparam logic [7:0] OFS_G1_HI     = 8'h63;
  localparam logic [7:0] OFS_TOL       = 8'h64;
  localparam logic [7:0] OFS_SPARE_A   = 8'h65;
  localparam logic [7:0] OFS_SPARE_B   = 8'h66;
  localparam logic [7:0] OFS_SPARE_C   = 8'h67;
  localparam logic [7:0] OFS_SPARE_D   = 8'h68;
  localparam logic [7:0] OFS_EYE_INTV  = 8'h69;
  localparam logic [7:0] OFS_EYE_THR   = 8'h6A;
  localparam logic [7:0] OFS_MERIT_A   = 8'h6B;
  localparam logic [7:0] OFS_MERIT_B   = 8'h6C;
  localparam logic [7:0] OFS_MERIT_C   = 8'h6D;

  // Field positions.
  localparam int ADAPT_ALT_BIT    = 4;
  localparam int ADAPT_LOWDIV_BIT = 0;
  localparam logic [7:0] ADAPT_OPT_WMASK = 8'h11;
  localparam int EV_LOCK_BIT      = 3;
  localparam int EV_SIG_ACQ_BIT   = 2;
  localparam int EV_LOCK_LOSS_BIT = 1;
  localparam int EV_SIG_LOSS_BIT  = 0;
  localparam int EV_W             = 4;
  localparam int OVR_BIT          = 7;

  // Values after reset.
  localparam logic [7:0] RST_ADAPT_OPT = 8'h00;
  localparam logic [7:0] RST_COUNT     = 8'h00;
  localparam logic [7:0] RST_TOL       = 8'h00;
  localparam logic [3:0] RST_EYE_INTV  = 4'hA;
  localparam logic [7:0] RST_EYE_THR   = 8'h44;
  localparam logic [7:0] RST_MERIT_A   = 8'h40;
  localparam logic [7:0] RST_MERIT_B   = 8'h00;
  localparam logic [7:0] RST_MERIT_C   = 8'h00;

  // Figure of merit scaling.
  localparam logic [7:0] MERIT_SPAN = 8'h80;
  localparam logic [6:0] MERIT_DIV  = 7'h7F;

  // Monitoring interval at the reset setting of the timing select.
  localparam int CLK_FREQ_MHZ        = 50;
  localparam int EYE_INTERVAL_US     = 6500;
  localparam int EYE_INTERVAL_CYCLES = EYE_INTERVAL_US * CLK_FREQ_MHZ;
  localparam int TIMER_W             = 24;

  typedef struct packed {
    logic       valid;
    logic [7:0] horizontal_eye_opening;
    logic [7:0] vertical_eye_opening;
    logic [7:0] alt_heo;
    logic [7:0] alt_veo;
  } rlmp_eye_t;

  typedef struct packed {
    logic [14:0] count;
    logic [3:0]  tol;
  } rlmp_ppm_t;

  typedef struct packed {
    logic [7:0] adapt_opt;
    logic [7:0] g0_lo;
    logic [7:0] g0_hi;
    logic [7:0] g1_lo;
    logic [7:0] g1_hi;
    logic [7:0] tol;
    logic [3:0] eye_intv;
    logic [7:0] eye_thr;
    logic [7:0] merit_a;
    logic [7:0] merit_b;
    logic [7:0] merit_c;
  } rlmp_regs_t;

  typedef struct packed {
    rlmp_regs_t         regs;
    logic [7:0]         rdata;
    logic [1:0]         lock_sync;
    logic [1:0]         sig_sync;
    logic               lock_prev;
    logic               sig_prev;
    logic [TIMER_W-1:0] timer;
    logic [3:0]         intv_cnt;
    logic               meas_req;
    logic               eye_low;
    logic [7:0]         readback_h;
    logic [7:0]         readback_v;
    logic [9:0]         score;
  } rlmp_state_t;

endpackage

// ### rlmp_sticky.sv
// Bank of sticky event flags that clear on a register read.
// Assumes set pulses and the clear strobe come from logic on the same clock.
module rlmp_sticky
  import rlmp_pkg::*;
#(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Events and clear
  input  wire logic [W-1:0] set,
  input  wire logic         clr,
  // Flags
  output logic      [W-1:0] flags
);

  initial begin
    if (W < 1) begin
      $error("rlmp_sticky needs at least one flag");
    end
  end

  logic [W-1:0] next_flags;

  // A set in the clearing cycle survives, so no event is lost.
  always_comb begin
    next_flags = (flags & ~{W{clr}}) | set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

endmodule

// ### rlmp_merit.sv
// Adaptation figure of merit from the eye openings and three weighting terms.
// Purely combinational; the caller registers the result.
module rlmp_merit
  import rlmp_pkg::*;
(
  // Eye openings
  input  wire logic [7:0] horizontal_eye_opening,
  input  wire logic [7:0] vertical_eye_opening,
  // Weighting terms
  input  wire logic [7:0] term_a,
  input  wire logic [7:0] term_b,
  input  wire logic [7:0] term_c,
  // Score
  output logic      [9:0] score
);

  logic [7:0]  h_diff;
  logic [7:0]  v_diff;
  logic [7:0]  v_weight;
  logic [15:0] h_prod;
  logic [15:0] v_prod;
  logic [15:0] h_term;
  logic [15:0] v_term;

  // Negative differences and weights clamp to zero rather than wrap around.
  always_comb begin
    h_diff   = (horizontal_eye_opening > term_b) ? horizontal_eye_opening - term_b : 8'h00;
    v_diff   = (vertical_eye_opening > term_c) ? vertical_eye_opening - term_c : 8'h00;
    v_weight = (term_a < MERIT_SPAN) ? MERIT_SPAN - term_a : 8'h00;
    h_prod   = h_diff * term_a;
    v_prod   = v_diff * v_weight;
    h_term   = h_prod / {9'h000, MERIT_DIV};
    v_term   = v_prod / {9'h000, MERIT_DIV};
    score    = (h_term < v_term) ? h_term[9:0] : v_term[9:0];
  end

endmodule

// ### rlmp_eye_model.sv
// Stand-in for the eye monitor that answers the bank's measurement requests.
// Assumes requests are one-cycle pulses on clk and openings are set by the bench.
module rlmp_eye_model
  import rlmp_pkg::*;
#(
  parameter int DELAY = 3
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Request and openings to report
  input  wire logic       meas_req,
  input  wire logic [7:0] horizontal_eye_opening,
  input  wire logic [7:0] vertical_eye_opening,
  input  wire logic [7:0] alt_heo,
  input  wire logic [7:0] alt_veo,
  // Result
  output rlmp_eye_t       eye
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DELAY-1:0] pipe;
  logic [7:0]       noise;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pipe  <= '0;
      noise <= 8'hA5;
    end else begin
      pipe  <= {pipe[DELAY-2:0], meas_req};
      noise <= {noise[6:0], noise[7] ^ noise[5]};
    end
  end
  // Openings mean nothing without valid, so they wander in between.
  always_comb begin
    eye.valid   = pipe[DELAY-1];
    eye.horizontal_eye_opening     = eye.valid ? horizontal_eye_opening : noise;
    eye.vertical_eye_opening     = eye.valid ? vertical_eye_opening : ~noise;
    eye.alt_heo = eye.valid ? alt_heo : noise ^ 8'h3C;
    eye.alt_veo = eye.valid ? alt_veo : noise ^ 8'hC3;
  end
endmodule

// ### tb.sv
// Self-checking bench for the lock monitor and PPM register bank.
// Assumes the bank runs alone on a 50 MHz clock with the eye model at its far side.
module tb;
  import rlmp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INTV = 20;
  typedef struct packed {
    logic [7:0] h;
    logic [7:0] v;
    logic [9:0] s;
    logic       b;
  } rlmp_note_t;
  logic       clk, arst_n, reg_wr, reg_rd, cdr_lock_raw, sig_detect_raw;
  logic       adapt_done, mon_enable, adapt_lowdiv_en, eye_monitoring;
  logic       eye_meas_req, eye_below_thr, rd_d, ev_d;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, readback_h, readback_v, acc;
  logic [7:0] m_heo, m_veo, m_ahe, m_ave;
  logic [1:0] interval_sel;
  logic [9:0] merit_score;
  logic [8:0] note;
  logic [31:0] seed = 32'hCEE3C9D8;
  rlmp_eye_t  eye;
  rlmp_ppm_t  ppm_g0, ppm_g1;
  rlmp_note_t en;
  logic [8:0] rq[$];
  rlmp_note_t eq[$];
  int n_mismatch = 0;
  int tests_run = 0;
  int n;
  logic [7:0] adr [17] = '{8'h55, 8'h56, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66,
                           8'h67, 8'h68, 8'h69, 8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h70};
  logic [7:0] msk [17] = '{8'h11, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00,
                           8'h00, 8'h00, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
  logic [7:0] rsv [17] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'h00, 8'h00, 8'h0A, 8'h44, 8'h40, 8'h00, 8'h00, 8'h00};

  rlmp_bank #(
    .INTERVAL_CYCLES(INTV),
    .G0_FIXED_COUNT (15'h0123),
    .G0_FIXED_TOL   (4'h7),
    .G1_FIXED_COUNT (15'h0ABC),
    .G1_FIXED_TOL   (4'h3)
  ) dut_u (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cdr_lock_raw(cdr_lock_raw),
    .sig_detect_raw(sig_detect_raw), .adapt_done(adapt_done), .mon_enable(mon_enable),
    .interval_sel(interval_sel), .eye(eye), .adapt_lowdiv_en(adapt_lowdiv_en),
    .ppm_g0(ppm_g0), .ppm_g1(ppm_g1), .eye_monitoring(eye_monitoring),
    .eye_meas_req(eye_meas_req), .eye_below_thr(eye_below_thr), .readback_h(readback_h),
    .readback_v(readback_v), .merit_score(merit_score)
  );

  rlmp_eye_model eye_u (
    .clk(clk), .arst_n(arst_n), .meas_req(eye_meas_req), .horizontal_eye_opening(m_heo), .vertical_eye_opening(m_veo),
    .alt_heo(m_ahe), .alt_veo(m_ave), .eye(eye)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [9:0] adaptation_merit_score(input int h, v, a, b, c);
    int x, y;
    x = (h > b ? h - b : 0) * a / 127;
    y = (v > c ? v - c : 0) * (a > 128 ? 0 : 128 - a) / 127;
    return 10'(x < y ? x : y);
  endfunction

  // Each access leaves an idle cycle so no strobe is driven twice in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk) #2 reg_wr = 1'b0;
    @(posedge clk) #2;
  endtask

  task automatic rd(input logic [7:0] a, input logic [8:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    rq.push_back(exp);
    @(posedge clk) #2 reg_rd = 1'b0;
    @(posedge clk) #2;
  endtask

  task automatic wait_hi(input bit valid_sig, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk) #2;
      cnt++;
    end while ((valid_sig ? eye.valid : eye_meas_req) !== 1'b1 && cnt < 1000);
    if (cnt >= 1000) begin
      n_mismatch++;
      finish_test();
    end
  endtask

  task automatic eye_case(input logic [7:0] opt, a, b, c, thr, h, v, ah, av);
    wr(8'h55, opt);
    wr(8'h6B, a);
    wr(8'h6C, b);
    wr(8'h6D, c);
    wr(8'h6A, thr);
    {m_heo, m_veo, m_ahe, m_ave} = {h, v, ah, av};
    en.h = opt[4] ? ah : h;
    en.v = opt[4] ? av : v;
    en.s = adaptation_merit_score(en.h, en.v, a, b, c);
    en.b = (v[7:4] < thr[7:4]) | (h[7:4] < thr[3:0]);
    eq.push_back(en);
    mon_enable = 1'b1;
    wait_hi(1'b1, n);
    // Monitoring stays on through the capture edge so the threshold flag updates.
    @(posedge clk) #2 mon_enable = 1'b0;
    repeat (2) @(posedge clk);
    #2;
  endtask

  // Results are taken off the queues in the cycle after they are launched.
  always @(posedge clk) begin
    rd_d <= reg_rd;
    ev_d <= eye.valid & eye_monitoring;
    if (rd_d) begin
      note = rq.pop_front();
      if (note[8]) acc = acc | reg_rdata;
      else chk("reg_rdata", note[7:0], reg_rdata);
    end
    if (ev_d && eq.size() > 0) begin
      en = eq.pop_front();
      chk("readback_h", en.h, readback_h);
      chk("readback_v", en.v, readback_v);
      chk("merit_score", en.s, merit_score);
      chk("eye_below_thr", en.b, eye_below_thr);
    end
  end

  initial begin
    {arst_n, reg_wr, reg_rd, cdr_lock_raw, sig_detect_raw, adapt_done, mon_enable} = '0;
    {reg_addr, reg_wdata, interval_sel, acc} = '0;
    {m_heo, m_veo, m_ahe, m_ave} = '0;
    repeat (16) @(posedge clk);
    #2 arst_n = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    for (int i = 0; i < 17; i++) rd(adr[i], {1'b0, rsv[i]});
    for (int i = 0; i < 17; i++) begin
      seed = lfsr(seed);
      wr(adr[i], seed[7:0]);
      rd(adr[i], {1'b0, (seed[7:0] & msk[i]) | (rsv[i] & ~msk[i])});
    end
    wr(8'h55, 8'h01);
    chk("adapt_lowdiv_en", 1'b1, adapt_lowdiv_en);
    wr(8'h55, 8'h10);
    chk("adapt_lowdiv_en", 1'b0, adapt_lowdiv_en);
    wr(8'h60, 8'h34);
    wr(8'h61, 8'h92);
    wr(8'h62, 8'h78);
    wr(8'h63, 8'h56);
    wr(8'h64, 8'hA5);
    chk("ppm_g0", {15'h1234, 4'hA}, ppm_g0);
    chk("ppm_g1", {15'h0ABC, 4'h3}, ppm_g1);
    wr(8'h63, 8'hD6);
    wr(8'h64, 8'h3C);
    wr(8'h61, 8'h12);
    chk("ppm_g1", {15'h5678, 4'hC}, ppm_g1);
    chk("ppm_g0", {15'h0123, 4'h7}, ppm_g0);
    cdr_lock_raw = 1'b1;
    repeat (6) @(posedge clk);
    #2 cdr_lock_raw = 1'b0;
    repeat (6) @(posedge clk);
    #2 sig_detect_raw = 1'b1;
    repeat (6) @(posedge clk);
    #2 sig_detect_raw = 1'b0;
    repeat (6) @(posedge clk);
    #2;
    rd(8'h56, 9'h00F);
    rd(8'h56, 9'h000);
    acc = 8'h00;
    {sig_detect_raw, cdr_lock_raw} = 2'h3;
    reg_addr = 8'h56;
    reg_rd = 1'b1;
    repeat (8) begin
      rq.push_back(9'h100);
      @(posedge clk) #2;
    end
    reg_rd = 1'b0;
    @(posedge clk) #2;
    rd(8'h56, 9'h000);
    chk("event_accumulated", 8'h0C, acc);
    for (int i = 0; i < 8; i++) begin
      {mon_enable, adapt_done, cdr_lock_raw} = 3'(i);
      repeat (4) @(posedge clk);
      #2 chk("eye_monitoring", i == 7, eye_monitoring);
    end
    wr(8'h69, 8'h02);
    for (int s = 0; s < 4; s++) begin
      interval_sel = 2'(s);
      wait_hi(1'b0, n);
      wait_hi(1'b0, n);
      chk("request_gap", INTV * (s + 1) * 2, n);
    end
    mon_enable = 1'b0;
    interval_sel = 2'h0;
    wr(8'h69, 8'h01);
    eye_case(8'h00, 8'h7F, 8'h10, 8'h01, 8'h44, 8'h30, 8'hFF, 8'h21, 8'h9F);
    eye_case(8'h10, 8'h7F, 8'h10, 8'h01, 8'h44, 8'h50, 8'hFF, 8'h51, 8'h80);
    eye_case(8'h00, 8'h7F, 8'h10, 8'h01, 8'h95, 8'h50, 8'h85, 8'h22, 8'h33);
    eye_case(8'h00, 8'h40, 8'hF0, 8'h00, 8'h00, 8'h30, 8'h40, 8'h11, 8'h22);
    chk("eye_notes_left", 0, eq.size());
    finish_test();
  end
endmodule
